/* File: common/dsmc_defs.svh */
// constants of the drive state machine controller: object indices,
// control/status bit positions, status codes and reset values.
// assumes inclusion by bare name from design files only.
`ifndef DSMC_DEFS_SVH
`define DSMC_DEFS_SVH

`define DSMC_IDX_CTRL 16'h6040
`define DSMC_IDX_STAT 16'h6041
`define DSMC_IDX_MODE_REQ 16'h6060
`define DSMC_IDX_MODE_ACT 16'h6061
`define DSMC_IDX_MODE_SUP 16'h6502

`define DSMC_CW_SWON 0
`define DSMC_CW_VOLT 1
`define DSMC_CW_QSTOP 2
`define DSMC_CW_ENOP 3
`define DSMC_CW_FRST 7

`define DSMC_SW_VOLT 4

`define DSMC_CODE_NRDY 7'h00
`define DSMC_CODE_SOD 7'h60
`define DSMC_CODE_RTSO 7'h21
`define DSMC_CODE_SON 7'h23
`define DSMC_CODE_OPEN 7'h27
`define DSMC_CODE_QSA 7'h07
`define DSMC_CODE_FRA 7'h2f
`define DSMC_CODE_FLT 7'h28

`define DSMC_CW_RESET 16'h0000
`define DSMC_SW_RESET 16'h0000
`define DSMC_MODE_NONE 8'h00
`define DSMC_DATA_ZERO 32'h0000_0000

`endif

/* File: common/dsmc_pkg.sv */
// types of the drive state machine controller.
// assumes dsmc_defs.svh holds the numeric constants.
package dsmc_pkg;

  typedef enum logic [2:0] {
    DSMC_NOT_READY = 3'h0,
    DSMC_SW_ON_DIS = 3'h1,
    DSMC_READY = 3'h2,
    DSMC_SWITCHED_ON = 3'h3,
    DSMC_OP_ENABLED = 3'h4,
    DSMC_QSTOP_ACTIVE = 3'h5,
    DSMC_FAULT_REACT = 3'h6,
    DSMC_FAULT = 3'h7
  } dsmc_state_e;

  typedef enum logic [2:0] {
    DSMC_CMD_NONE = 3'h0,
    DSMC_CMD_DIS_VOLT = 3'h1,
    DSMC_CMD_QSTOP = 3'h2,
    DSMC_CMD_SHUTDOWN = 3'h3,
    DSMC_CMD_SWON = 3'h4,
    DSMC_CMD_ENABLE = 3'h5
  } dsmc_cmd_e;

  typedef enum logic [2:0] {
    DSMC_KIND_NONE = 3'h0,
    DSMC_KIND_POS = 3'h1,
    DSMC_KIND_VEL = 3'h2,
    DSMC_KIND_TRQ = 3'h3,
    DSMC_KIND_HOM = 3'h4
  } dsmc_kind_e;

endpackage : dsmc_pkg

/* File: common/dsmc_cmd_if.sv */
// carries the stored control word to the command decoder and the
// decoded command back. assumes one clock domain, no timing of its own.
`timescale 1ns/1ps
interface dsmc_cmd_if;
  logic [15:0] ctrl_word;
  logic frst_prev;
  dsmc_pkg::dsmc_cmd_e cmd;
  logic fault_reset;

  modport decoder(input ctrl_word, input frst_prev, output cmd, output fault_reset);
  modport core(output ctrl_word, output frst_prev, input cmd, input fault_reset);
endinterface : dsmc_cmd_if

/* File: rtl/dsmc_cmd_decode.sv */
// decodes the control word into one state machine command.
// assumes the core holds the word and the last bit-7 sample.
`timescale 1ns/1ps
`include "dsmc_defs.svh"

module dsmc_cmd_decode (
  dsmc_cmd_if.decoder cif
);

  //////////////////////////////////////////////////////////////////////
  // switch-on and disable-operation share a code; the core splits them
  always_comb begin
    if (!cif.ctrl_word[`DSMC_CW_VOLT]) begin
      cif.cmd = dsmc_pkg::DSMC_CMD_DIS_VOLT;
    end else if (!cif.ctrl_word[`DSMC_CW_QSTOP]) begin
      cif.cmd = dsmc_pkg::DSMC_CMD_QSTOP;
    end else if (!cif.ctrl_word[`DSMC_CW_SWON]) begin
      cif.cmd = dsmc_pkg::DSMC_CMD_SHUTDOWN;
    end else if (!cif.ctrl_word[`DSMC_CW_ENOP]) begin
      cif.cmd = dsmc_pkg::DSMC_CMD_SWON;
    end else begin
      cif.cmd = dsmc_pkg::DSMC_CMD_ENABLE;
    end
  end

  // bit 7 only matters as a rising edge
  assign cif.fault_reset = cif.ctrl_word[`DSMC_CW_FRST] & ~cif.frst_prev;

endmodule : dsmc_cmd_decode

/* File: rtl/dsmc_top.sv */
// drive state machine controller: object access, state machine,
// status word, operation modes and per-mode function enables.
// assumes servo_alarm is a pin; all other inputs are on core_clk.
`timescale 1ns/1ps
`include "dsmc_defs.svh"

module dsmc_top #(
  parameter int INIT_CYCLES = 16,
  parameter logic [55:0] MODE_CODES = {8'h0a, 8'h09, 8'h08, 8'h06, 8'h04, 8'h03, 8'h01}
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic obj_req,
  input wire logic obj_we,
  input wire logic [15:0] obj_index,
  input wire logic [31:0] obj_wdata,
  output logic [31:0] obj_rdata,
  output logic obj_ack,
  output logic obj_err,
  input wire logic servo_alarm,
  input wire logic alarm_seq_done,
  input wire logic qstop_done,
  input wire logic homing_pos_ctrl,
  input wire logic stat_warning,
  input wire logic stat_remote,
  input wire logic stat_target_reached,
  input wire logic stat_internal_limit,
  input wire logic [1:0] stat_mode_specific,
  input wire logic stat_abs_valid,
  input wire logic stat_busy,
  output logic servo_on,
  output logic main_power_allow,
  output logic main_power_on,
  output logic quick_stop_run,
  output logic alarm_seq_run,
  output logic fault_active,
  output logic [15:0] drive_status_word,
  output logic [7:0] active_operation_mode,
  output logic gear_en,
  output logic rt_gain_en,
  output logic notch_en,
  output logic speed_ff_en,
  output logic pos_filt_en,
  output logic torque_ff_en,
  output logic dist_obs_en
);

  localparam int NMODES = 7;
  localparam int IW = $clog2(INIT_CYCLES + 1);

  if (INIT_CYCLES < 1) begin : g_chk_init
    $error("INIT_CYCLES must be at least 1");
  end

  //////////////////////////////////////////////////////////////////////
  // mode table; index 0,4 position, 1,5 velocity, 2,6 torque, 3 homing
  logic [NMODES-1:0] mode_hit;
  logic [31:0] mask_chain [NMODES+1];
  assign mask_chain[0] = `DSMC_DATA_ZERO;

  for (genvar i = 0; i < NMODES; i++) begin : g_mode
    localparam logic [7:0] CODE = MODE_CODES[8*i +: 8];
    if (CODE == 8'h00 || CODE > 8'h20) begin : g_chk_code
      $error("mode code must lie in 1..32");
    end
    assign mode_hit[i] = (obj_wdata[7:0] == CODE);
    assign mask_chain[i+1] = mask_chain[i] | (32'h1 << (CODE - 8'h01));
  end

  //////////////////////////////////////////////////////////////////////
  // alarm pin synchroniser
  logic alarm_m;
  logic alarm_s;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      alarm_m <= 1'b0;
      alarm_s <= 1'b0;
    end else begin
      alarm_m <= servo_alarm;
      alarm_s <= alarm_m;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // command decoder
  dsmc_cmd_if cif ();
  dsmc_cmd_decode u_dec (.cif(cif.decoder));

  logic [15:0] ctrl_word;
  logic frst_prev;
  assign cif.ctrl_word = ctrl_word;
  assign cif.frst_prev = frst_prev;

  //////////////////////////////////////////////////////////////////////
  // object access and mode store
  dsmc_pkg::dsmc_state_e state;
  dsmc_pkg::dsmc_kind_e kind;
  logic [15:0] next_ctrl_word;
  logic [7:0] next_mode;
  dsmc_pkg::dsmc_kind_e next_kind;
  logic [31:0] next_rdata;
  logic next_err;

  always_comb begin
    next_ctrl_word = ctrl_word;
    next_mode = active_operation_mode;
    next_kind = kind;
    next_rdata = `DSMC_DATA_ZERO;
    next_err = 1'b0;
    if (obj_req) begin
      unique case (obj_index)
        `DSMC_IDX_CTRL: begin
          if (obj_we) begin
            next_ctrl_word = obj_wdata[15:0];
          end
          next_rdata = {16'h0000, ctrl_word};
        end
        `DSMC_IDX_STAT: begin
          next_err = obj_we;
          next_rdata = {16'h0000, drive_status_word};
        end
        `DSMC_IDX_MODE_REQ, `DSMC_IDX_MODE_ACT: begin
          // unknown codes refused so the display never shows a bad mode
          if (obj_we && obj_index == `DSMC_IDX_MODE_REQ) begin
            if (|mode_hit && obj_wdata[31:8] == 24'h00_0000) begin
              next_mode = obj_wdata[7:0];
              if (mode_hit[3]) begin
                next_kind = dsmc_pkg::DSMC_KIND_HOM;
              end else if (mode_hit[0] || mode_hit[4]) begin
                next_kind = dsmc_pkg::DSMC_KIND_POS;
              end else if (mode_hit[1] || mode_hit[5]) begin
                next_kind = dsmc_pkg::DSMC_KIND_VEL;
              end else begin
                next_kind = dsmc_pkg::DSMC_KIND_TRQ;
              end
            end else begin
              next_err = 1'b1;
            end
          end else begin
            next_err = obj_we;
          end
          next_rdata = {24'h00_0000, active_operation_mode};
        end
        `DSMC_IDX_MODE_SUP: begin
          next_err = obj_we;
          next_rdata = mask_chain[NMODES];
        end
        default: begin
          next_err = 1'b1;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state machine
  dsmc_pkg::dsmc_state_e next_state;
  logic [IW-1:0] init_cnt;
  logic [IW-1:0] next_init_cnt;
  logic alarm_path;

  // any state with main logic live reacts to a new alarm first
  assign alarm_path = alarm_s && state != dsmc_pkg::DSMC_NOT_READY
    && state != dsmc_pkg::DSMC_FAULT_REACT && state != dsmc_pkg::DSMC_FAULT;

  always_comb begin
    next_state = state;
    next_init_cnt = init_cnt;
    if (alarm_path) begin
      next_state = dsmc_pkg::DSMC_FAULT_REACT;
    end else begin
      unique case (state)
        dsmc_pkg::DSMC_NOT_READY: begin
          if (init_cnt == IW'(INIT_CYCLES - 1)) begin
            next_state = dsmc_pkg::DSMC_SW_ON_DIS;
          end else begin
            next_init_cnt = init_cnt + IW'(1);
          end
        end
        dsmc_pkg::DSMC_SW_ON_DIS: begin
          if (cif.cmd == dsmc_pkg::DSMC_CMD_SHUTDOWN) begin
            next_state = dsmc_pkg::DSMC_READY;
          end
        end
        dsmc_pkg::DSMC_READY: begin
          unique case (cif.cmd)
            dsmc_pkg::DSMC_CMD_DIS_VOLT, dsmc_pkg::DSMC_CMD_QSTOP:
              next_state = dsmc_pkg::DSMC_SW_ON_DIS;
            dsmc_pkg::DSMC_CMD_SWON, dsmc_pkg::DSMC_CMD_ENABLE:
              next_state = dsmc_pkg::DSMC_SWITCHED_ON;
            default: next_state = state;
          endcase
        end
        dsmc_pkg::DSMC_SWITCHED_ON: begin
          unique case (cif.cmd)
            dsmc_pkg::DSMC_CMD_DIS_VOLT, dsmc_pkg::DSMC_CMD_QSTOP:
              next_state = dsmc_pkg::DSMC_SW_ON_DIS;
            dsmc_pkg::DSMC_CMD_SHUTDOWN: next_state = dsmc_pkg::DSMC_READY;
            dsmc_pkg::DSMC_CMD_ENABLE: next_state = dsmc_pkg::DSMC_OP_ENABLED;
            default: next_state = state;
          endcase
        end
        dsmc_pkg::DSMC_OP_ENABLED: begin
          unique case (cif.cmd)
            dsmc_pkg::DSMC_CMD_DIS_VOLT: next_state = dsmc_pkg::DSMC_SW_ON_DIS;
            dsmc_pkg::DSMC_CMD_QSTOP: next_state = dsmc_pkg::DSMC_QSTOP_ACTIVE;
            dsmc_pkg::DSMC_CMD_SHUTDOWN: next_state = dsmc_pkg::DSMC_READY;
            dsmc_pkg::DSMC_CMD_SWON: next_state = dsmc_pkg::DSMC_SWITCHED_ON;
            default: next_state = state;
          endcase
        end
        dsmc_pkg::DSMC_QSTOP_ACTIVE: begin
          if (cif.cmd == dsmc_pkg::DSMC_CMD_DIS_VOLT || qstop_done) begin
            next_state = dsmc_pkg::DSMC_SW_ON_DIS;
          end else if (cif.cmd == dsmc_pkg::DSMC_CMD_ENABLE) begin
            next_state = dsmc_pkg::DSMC_OP_ENABLED;
          end
        end
        dsmc_pkg::DSMC_FAULT_REACT: begin
          if (alarm_seq_done) begin
            next_state = dsmc_pkg::DSMC_FAULT;
          end
        end
        dsmc_pkg::DSMC_FAULT: begin
          // reset edge is lost while the alarm still stands
          if (cif.fault_reset && !alarm_s) begin
            next_state = dsmc_pkg::DSMC_SW_ON_DIS;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // next outputs from next state and mode
  logic [6:0] next_code;
  logic next_volt;
  logic [15:0] next_status;
  logic [6:0] next_outs;
  logic [3:0] next_fen;

  always_comb begin
    next_volt = 1'b0;
    next_outs = 7'h00;
    next_code = `DSMC_CODE_NRDY;
    unique case (next_state)
      dsmc_pkg::DSMC_NOT_READY: next_code = `DSMC_CODE_NRDY;
      dsmc_pkg::DSMC_SW_ON_DIS: next_code = `DSMC_CODE_SOD;
      dsmc_pkg::DSMC_READY: begin
        next_code = `DSMC_CODE_RTSO;
        next_outs = 7'b0001000;
      end
      dsmc_pkg::DSMC_SWITCHED_ON: begin
        next_code = `DSMC_CODE_SON;
        next_outs = 7'b0001100;
        next_volt = 1'b1;
      end
      dsmc_pkg::DSMC_OP_ENABLED: begin
        next_code = `DSMC_CODE_OPEN;
        next_outs = 7'b0001110;
        next_volt = 1'b1;
      end
      dsmc_pkg::DSMC_QSTOP_ACTIVE: begin
        next_code = `DSMC_CODE_QSA;
        next_outs = 7'b0011100;
        next_volt = 1'b1;
      end
      dsmc_pkg::DSMC_FAULT_REACT: begin
        next_code = `DSMC_CODE_FRA;
        next_outs = 7'b1100000;
        next_volt = 1'b1;
      end
      dsmc_pkg::DSMC_FAULT: begin
        next_code = `DSMC_CODE_FLT;
        next_outs = 7'b1000000;
      end
    endcase
    next_status = {stat_busy, stat_abs_valid, stat_mode_specific, stat_internal_limit,
      stat_target_reached, stat_remote, 1'b0, stat_warning, next_code};
    next_status[`DSMC_SW_VOLT] = next_volt;
    // speed ff, position filter, torque ff, observer
    unique case (next_kind)
      dsmc_pkg::DSMC_KIND_POS: next_fen = 4'b1111;
      dsmc_pkg::DSMC_KIND_VEL: next_fen = 4'b0011;
      dsmc_pkg::DSMC_KIND_HOM: next_fen = {homing_pos_ctrl, homing_pos_ctrl, 2'b11};
      default: next_fen = 4'b0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // registers
  logic next_common;
  assign next_common = (next_kind != dsmc_pkg::DSMC_KIND_NONE);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= dsmc_pkg::DSMC_NOT_READY;
      init_cnt <= '0;
      ctrl_word <= `DSMC_CW_RESET;
      frst_prev <= 1'b0;
      kind <= dsmc_pkg::DSMC_KIND_NONE;
      active_operation_mode <= `DSMC_MODE_NONE;
      obj_rdata <= `DSMC_DATA_ZERO;
      obj_ack <= 1'b0;
      obj_err <= 1'b0;
      drive_status_word <= `DSMC_SW_RESET;
      {fault_active, alarm_seq_run, quick_stop_run, main_power_allow, main_power_on,
        servo_on, gear_en} <= 7'h00;
      {rt_gain_en, notch_en} <= 2'b00;
      {speed_ff_en, pos_filt_en, torque_ff_en, dist_obs_en} <= 4'h0;
    end else begin
      state <= next_state;
      init_cnt <= next_init_cnt;
      ctrl_word <= next_ctrl_word;
      frst_prev <= ctrl_word[`DSMC_CW_FRST];
      kind <= next_kind;
      active_operation_mode <= next_mode;
      obj_rdata <= next_rdata;
      obj_ack <= obj_req;
      obj_err <= next_err;
      drive_status_word <= next_status;
      {fault_active, alarm_seq_run, quick_stop_run, main_power_allow, main_power_on,
        servo_on, gear_en} <= {next_outs[6:1], next_common};
      {rt_gain_en, notch_en} <= {next_common, next_common};
      {speed_ff_en, pos_filt_en, torque_ff_en, dist_obs_en} <= next_fen;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  sequence s_alarm_hit;
    alarm_s && state inside {dsmc_pkg::DSMC_SW_ON_DIS, dsmc_pkg::DSMC_READY,
      dsmc_pkg::DSMC_SWITCHED_ON, dsmc_pkg::DSMC_OP_ENABLED, dsmc_pkg::DSMC_QSTOP_ACTIVE};
  endsequence

  sequence s_fault_clear;
    state == dsmc_pkg::DSMC_FAULT && !alarm_s && ctrl_word[`DSMC_CW_FRST] && !frst_prev;
  endsequence

  property p_init_exit;
    @(posedge core_clk) disable iff (rst)
      $fell(rst) |-> state == dsmc_pkg::DSMC_NOT_READY ##[1:64] state == dsmc_pkg::DSMC_SW_ON_DIS;
  endproperty
  a_init_exit: assert property (p_init_exit) else $error("init did not finish");

  property p_sod_power;
    @(posedge core_clk) disable iff (rst)
      state == dsmc_pkg::DSMC_SW_ON_DIS |-> !main_power_allow && drive_status_word[6:0] == 7'h60;
  endproperty
  a_sod_power: assert property (p_sod_power) else $error("power allowed when disabled");

  property p_ready_out;
    @(posedge core_clk) disable iff (rst)
      state == dsmc_pkg::DSMC_READY |-> main_power_allow && !main_power_on && !servo_on;
  endproperty
  a_ready_out: assert property (p_ready_out) else $error("ready outputs wrong");

  property p_swon_out;
    @(posedge core_clk) disable iff (rst)
      state == dsmc_pkg::DSMC_SWITCHED_ON |-> main_power_on && !servo_on;
  endproperty
  a_swon_out: assert property (p_swon_out) else $error("switched-on outputs wrong");

  property p_servo_on;
    @(posedge core_clk) disable iff (rst)
      servo_on == (state == dsmc_pkg::DSMC_OP_ENABLED);
  endproperty
  a_servo_on: assert property (p_servo_on) else $error("servo on outside enabled");

  property p_alarm_seq;
    @(posedge core_clk) disable iff (rst)
      s_alarm_hit |=> state == dsmc_pkg::DSMC_FAULT_REACT && alarm_seq_run && !servo_on;
  endproperty
  a_alarm_seq: assert property (p_alarm_seq) else $error("alarm not taken");

  property p_fault_hold;
    @(posedge core_clk) disable iff (rst)
      state == dsmc_pkg::DSMC_FAULT && alarm_s |=> state == dsmc_pkg::DSMC_FAULT;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault left under alarm");

  property p_fault_reset;
    @(posedge core_clk) disable iff (rst)
      s_fault_clear |=> state == dsmc_pkg::DSMC_SW_ON_DIS ##0 drive_status_word[6:0] == 7'h60;
  endproperty
  a_fault_reset: assert property (p_fault_reset) else $error("fault reset ignored");

  property p_disable_op;
    @(posedge core_clk) disable iff (rst)
      state == dsmc_pkg::DSMC_OP_ENABLED && cif.cmd == dsmc_pkg::DSMC_CMD_SWON && !alarm_s
      |=> state == dsmc_pkg::DSMC_SWITCHED_ON ##0 !servo_on;
  endproperty
  a_disable_op: assert property (p_disable_op) else $error("disable operation failed");

  property p_trq_ff;
    @(posedge core_clk) disable iff (rst)
      kind == dsmc_pkg::DSMC_KIND_TRQ |-> !torque_ff_en && !dist_obs_en && !speed_ff_en;
  endproperty
  a_trq_ff: assert property (p_trq_ff) else $error("torque mode enables wrong");

endmodule : dsmc_top

/* File: bench/dsmc_power_stage.sv */
// model of the power stage beside the drive: ends quick stop and alarm sequences.
// assumes core_clk domain; delay picks a prompt or a slow answer.
`timescale 1ns/1ps
module dsmc_power_stage (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic quick_stop_run,
  input wire logic alarm_seq_run,
  input wire logic [3:0] delay,
  output logic qstop_done,
  output logic alarm_seq_done
);
  logic [3:0] cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // one pulse per sequence; idle low so a stale done cannot end the next one
  always_ff @(posedge core_clk) begin
    if (rst || !(quick_stop_run || alarm_seq_run)) begin
      cnt <= 4'h0;
      qstop_done <= 1'b0;
      alarm_seq_done <= 1'b0;
    end else begin
      cnt <= cnt + 4'h1;
      qstop_done <= quick_stop_run && cnt == delay;
      alarm_seq_done <= alarm_seq_run && cnt == delay;
    end
  end
endmodule : dsmc_power_stage

/* File: bench/testbench.sv */
// self-checking bench: object accesses, state walk, alarm, modes, status bits.
// assumes the design answers each access one cycle after the request.
`timescale 1ns/1ps
`define chk(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module testbench;
  logic core_clk, rst, obj_req, obj_we, obj_ack, obj_err, servo_alarm, homing_pos_ctrl;
  logic [15:0] obj_index, drive_status_word;
  logic [31:0] obj_wdata, obj_rdata;
  logic alarm_seq_done, qstop_done, stat_warning, stat_remote, stat_target_reached;
  logic stat_internal_limit, stat_abs_valid, stat_busy;
  logic [1:0] stat_mode_specific;
  logic servo_on, main_power_allow, main_power_on, quick_stop_run, alarm_seq_run;
  logic fault_active, gear_en, rt_gain_en, notch_en;
  logic speed_ff_en, pos_filt_en, torque_ff_en, dist_obs_en;
  logic [7:0] active_operation_mode;
  logic [3:0] resp_delay;
  logic [8:0] p;
  logic [7:0] mc [8] = '{8'h01, 8'h06, 8'h06, 8'h03, 8'h04, 8'h08, 8'h09, 8'h0a};
  logic [3:0] me [8] = '{4'hf, 4'hf, 4'h3, 4'h3, 4'h0, 4'hf, 4'h3, 4'h0};
  logic [7:0] hv = 8'h02;
  int error_cnt = 0;
  int n_compared = 0;
  int k;
  // short init count keeps the run brief
  dsmc_top #(.INIT_CYCLES(3)) u_dut (.core_clk, .rst, .obj_req, .obj_we, .obj_index,
    .obj_wdata, .obj_rdata, .obj_ack, .obj_err, .servo_alarm, .alarm_seq_done,
    .qstop_done, .homing_pos_ctrl, .stat_warning, .stat_remote, .stat_target_reached,
    .stat_internal_limit, .stat_mode_specific, .stat_abs_valid, .stat_busy, .servo_on,
    .main_power_allow, .main_power_on, .quick_stop_run, .alarm_seq_run, .fault_active,
    .drive_status_word, .active_operation_mode, .gear_en, .rt_gain_en, .notch_en,
    .speed_ff_en, .pos_filt_en, .torque_ff_en, .dist_obs_en);
  dsmc_power_stage u_stage (.core_clk, .rst, .quick_stop_run, .alarm_seq_run,
    .delay(resp_delay), .qstop_done, .alarm_seq_done);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // one access; starts and ends at a falling edge
  task automatic acc(input logic we, input logic [15:0] idx, input logic [31:0] wd,
                     input logic [31:0] exp, input logic e_err);
    obj_req = 1'b1;
    obj_we = we;
    obj_index = idx;
    obj_wdata = wd;
    @(negedge core_clk);
    obj_req = 1'b0;
    `chk("ack", 1'b1, obj_ack)
    `chk("err", e_err, obj_err)
    if (!we && !e_err) `chk("rdata", exp, obj_rdata)
    // idle cycle: the next call never drops and raises req in one step
    @(negedge core_clk);
  endtask : acc
  task automatic cw(input logic [15:0] w);
    acc(1'b1, 16'h6040, {16'h0000, w}, 32'h0, 1'b0);
  endtask : cw
  // bit 4 masked: voltage flag is a separate check
  task automatic wst(input logic [6:0] exp);
    int i;
    for (i = 0; i < 12 && (drive_status_word[6:0] & 7'h6f) !== exp; i++) @(negedge core_clk);
    `chk("state", exp, drive_status_word[6:0] & 7'h6f)
    if (i == 12) complete_run();
  endtask : wst
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, obj_req, obj_we, servo_alarm, homing_pos_ctrl} = 5'h10;
    {stat_warning, stat_remote, stat_target_reached, stat_internal_limit} = 4'h0;
    {stat_abs_valid, stat_busy, stat_mode_specific} = 4'h0;
    obj_index = 16'h0000;
    obj_wdata = 32'h0;
    resp_delay = 4'h4;
    repeat (4) @(negedge core_clk);
    `chk("reset status", 16'h0000, drive_status_word)
    rst = 1'b0;
    wst(7'h60);
    `chk("power allow", 1'b0, main_power_allow)
    `chk("common off", 3'h0, {gear_en, rt_gain_en, notch_en})
    acc(1'b0, 16'h6041, 32'h0, 32'h0000_0060, 1'b0);
    acc(1'b0, 16'h6502, 32'h0, 32'h0000_03ad, 1'b0);
    acc(1'b1, 16'h6502, 32'h1, 32'h0, 1'b1);
    acc(1'b1, 16'h6061, 32'h1, 32'h0, 1'b1);
    acc(1'b0, 16'h6042, 32'h0, 32'h0, 1'b1);
    for (k = 0; k < 8; k++) begin
      homing_pos_ctrl = hv[k];
      acc(1'b1, 16'h6060, {24'h0, mc[k]}, 32'h0, 1'b0);
      `chk("mode", mc[k], active_operation_mode)
      `chk("mode fns", me[k], {speed_ff_en, pos_filt_en, torque_ff_en, dist_obs_en})
      `chk("common", 3'h7, {gear_en, rt_gain_en, notch_en})
    end
    acc(1'b1, 16'h6060, 32'h02, 32'h0, 1'b1);
    acc(1'b1, 16'h6060, 32'h0101, 32'h0, 1'b1);
    acc(1'b0, 16'h6061, 32'h0, 32'h0a, 1'b0);
    acc(1'b0, 16'h6060, 32'h0, 32'h0a, 1'b0);
    cw(16'h0006);
    wst(7'h21);
    `chk("ready power", 2'b10, {main_power_allow, main_power_on})
    cw(16'h0007);
    wst(7'h23);
    `chk("on power", 3'b110, {main_power_allow, main_power_on, servo_on})
    cw(16'h000f);
    wst(7'h27);
    `chk("servo on", 2'b11, {servo_on, drive_status_word[4]})
    cw(16'h0087);
    wst(7'h23);
    `chk("servo off", 1'b0, servo_on)
    cw(16'h000f);
    wst(7'h27);
    resp_delay = 4'h6;
    cw(16'h000b);
    wst(7'h07);
    `chk("qstop run", 2'b10, {quick_stop_run, servo_on})
    wst(7'h60);
    `chk("sod volt", 1'b0, drive_status_word[4])
    cw(16'h0006);
    wst(7'h21);
    cw(16'h000f);
    wst(7'h27);
    cw(16'h0000);
    wst(7'h60);
    cw(16'h0006);
    wst(7'h21);
    servo_alarm = 1'b1;
    resp_delay = 4'h3;
    wst(7'h2f);
    `chk("react", 3'b110, {alarm_seq_run, fault_active, main_power_allow})
    wst(7'h28);
    `chk("fault", 2'b01, {alarm_seq_run, fault_active})
    // a reset edge while the alarm stands must be ignored
    cw(16'h0000);
    cw(16'h0080);
    repeat (4) @(negedge core_clk);
    `chk("held", 7'h28, drive_status_word[6:0] & 7'h6f)
    servo_alarm = 1'b0;
    repeat (4) @(negedge core_clk);
    cw(16'h0000);
    cw(16'h0080);
    wst(7'h60);
    `chk("cleared", 1'b0, fault_active)
    for (k = 0; k < 2; k++) begin
      p = (k == 0) ? 9'h0c9 : 9'h134;
      {stat_busy, stat_abs_valid, stat_mode_specific} = p[8:5];
      {stat_internal_limit, stat_target_reached, stat_remote} = p[4:2];
      stat_warning = p[0];
      repeat (2) @(negedge core_clk);
      `chk("upper status", p, drive_status_word[15:7])
    end
    complete_run();
  end
endmodule : testbench
